/* File: verilog/hbfm_map.svh */
// constants and bit positions of the half-bridge fault manager
// Notes on behaviour
// - overcurrent lasting the filter time latches the switch off and sets its flag
// - overcurrent or open load also sets load_error_summary, global bit 6
// - switch with overcurrent flag set stays off, high impedance
// - enable control bits are never altered by faults; only the stage shuts
// - separate overcurrent flags kept per high-side and low-side switch
// - open load latches its per-switch flag, output state unchanged
// - temperature pre-warning latches global bit 1, outputs unchanged
// - temperature shutdown latches global bit 2, all outputs off until cleared
// - undervoltage latches bit 5, outputs off, auto recovery, flag stays
// - overvoltage latches bit 4, outputs off, auto recovery, flag stays
// - fault_indicator_n goes low on any listed fault
// - high and low side never on together; dead time between them
// - flags never self-clear; only a host clear or enable low removes them
// - enable low resets all flags and turns every output off
`ifndef HBFM_MAP_SVH
`define HBFM_MAP_SVH
`define HBFM_GS_PREWARN 1
`define HBFM_GS_TSHUT 2
`define HBFM_GS_OV 4
`define HBFM_GS_UV 5
`define HBFM_GS_LOADERR 6
`define HBFM_GS_W 8
`define HBFM_CLK_MHZ 200
`define HBFM_FILTER_NS 10000
`define HBFM_DEAD_NS 1000
`endif

/* File: verilog/hbfm_pkg.sv */
// types of the half-bridge fault manager
`default_nettype none
package hbfm_pkg;
  typedef enum logic [1:0] {HBFM_OFF, HBFM_HS_ON, HBFM_LS_ON, HBFM_DEAD} hbfm_leg_e;
endpackage : hbfm_pkg
`default_nettype wire

/* File: verilog/hbfm_leg.sv */
// one half-bridge: overcurrent filters, flags and dead-time sequencer
`timescale 1ns/100ps
`default_nettype none
`include "hbfm_map.svh"
module hbfm_leg
  import hbfm_pkg::*;
#(
  parameter int FILT_CYC = 2000,
  parameter int DEAD_CYC = 200
)(
  input wire logic CLK,
  input wire logic NRST,
  input wire logic en,
  input wire logic hs_req,
  input wire logic ls_req,
  input wire logic hs_oc_det,
  input wire logic ls_oc_det,
  input wire logic hs_ol_det,
  input wire logic ls_ol_det,
  input wire logic hs_oc_clr,
  input wire logic ls_oc_clr,
  input wire logic hs_ol_clr,
  input wire logic ls_ol_clr,
  input wire logic global_off,
  output logic hs_oc,
  output logic ls_oc,
  output logic hs_ol,
  output logic ls_ol,
  output logic hs_on,
  output logic ls_on
);
  localparam int CW = $clog2(FILT_CYC + DEAD_CYC + 2);
  logic [CW-1:0] hs_cnt, ls_cnt, dt_cnt;
  hbfm_leg_e st, next_st;
  // ************************************
  // overcurrent filters
  // ************************************
  wire hs_oc_hit = hs_on && hs_oc_det && (hs_cnt == CW'(FILT_CYC - 1));
  wire ls_oc_hit = ls_on && ls_oc_det && (ls_cnt == CW'(FILT_CYC - 1));
  always_ff @(posedge CLK or negedge NRST)
    if (!NRST)
    begin
      hs_cnt <= '0;
      ls_cnt <= '0;
    end
    else
    begin
      hs_cnt <= (hs_on && hs_oc_det && !hs_oc_hit) ? hs_cnt + 1'b1 : '0;
      ls_cnt <= (ls_on && ls_oc_det && !ls_oc_hit) ? ls_cnt + 1'b1 : '0;
    end
  // ************************************
  // per-switch flags, set wins over clear
  // ************************************
  always_ff @(posedge CLK or negedge NRST)
    if (!NRST)
    begin
      hs_oc <= 1'b0;
      ls_oc <= 1'b0;
      hs_ol <= 1'b0;
      ls_ol <= 1'b0;
    end
    else if (!en)
    begin
      hs_oc <= 1'b0;
      ls_oc <= 1'b0;
      hs_ol <= 1'b0;
      ls_ol <= 1'b0;
    end
    else
    begin
      hs_oc <= hs_oc_hit | (hs_oc & ~hs_oc_clr) | (hs_oc & hs_oc_det);
      ls_oc <= ls_oc_hit | (ls_oc & ~ls_oc_clr) | (ls_oc & ls_oc_det);
      // open-load detect arrives already qualified by the live gate
      hs_ol <= hs_ol_det | (hs_ol & ~hs_ol_clr);
      ls_ol <= ls_ol_det | (ls_ol & ~ls_ol_clr);
    end
  // ************************************
  // dead-time sequencer
  // ************************************
  wire hs_ok = en && hs_req && !ls_req && !hs_oc && !hs_oc_hit && !global_off;
  wire ls_ok = en && ls_req && !hs_req && !ls_oc && !ls_oc_hit && !global_off;
  wire dt_done = (dt_cnt == CW'(DEAD_CYC - 1));
  always_comb
  begin
    next_st = st;
    case (st)
      HBFM_OFF: next_st = hs_ok ? HBFM_HS_ON : (ls_ok ? HBFM_LS_ON : HBFM_OFF);
      HBFM_HS_ON: next_st = hs_ok ? HBFM_HS_ON : HBFM_DEAD;
      HBFM_LS_ON: next_st = ls_ok ? HBFM_LS_ON : HBFM_DEAD;
      HBFM_DEAD: next_st = dt_done ? HBFM_OFF : HBFM_DEAD;
      default: next_st = HBFM_OFF;
    endcase
  end
  always_ff @(posedge CLK or negedge NRST)
    if (!NRST)
    begin
      st <= HBFM_OFF;
      dt_cnt <= '0;
    end
    else
    begin
      st <= next_st;
      dt_cnt <= (st == HBFM_DEAD && !dt_done) ? dt_cnt + 1'b1 : '0;
    end
  assign hs_on = (st == HBFM_HS_ON);
  assign ls_on = (st == HBFM_LS_ON);
endmodule : hbfm_leg
`default_nettype wire

/* File: verilog/hbfm_top.sv */
// twelve-leg fault manager with global flags and fault pin
`timescale 1ns/100ps
`default_nettype none
`include "hbfm_map.svh"
module hbfm_top
  import hbfm_pkg::*;
#(
  parameter int LEGS = 12,
  parameter int FILT_CYC = (`HBFM_FILTER_NS * `HBFM_CLK_MHZ + 999) / 1000,
  parameter int DEAD_CYC = (`HBFM_DEAD_NS * `HBFM_CLK_MHZ + 999) / 1000
)(
  input wire logic CLK,
  input wire logic NRST,
  input wire logic EN,
  input wire logic [LEGS-1:0] HIGH_SIDE_ENABLE,
  input wire logic [LEGS-1:0] LOW_SIDE_ENABLE,
  input wire logic [LEGS-1:0] HS_OC_DET,
  input wire logic [LEGS-1:0] LS_OC_DET,
  input wire logic [LEGS-1:0] HS_OL_DET,
  input wire logic [LEGS-1:0] LS_OL_DET,
  input wire logic TEMP_WARN_DET,
  input wire logic TEMP_SD_DET,
  input wire logic SUPPLY_UV_DET,
  input wire logic SUPPLY_OV_DET,
  input wire logic [LEGS-1:0] HS_OC_CLR,
  input wire logic [LEGS-1:0] LS_OC_CLR,
  input wire logic [LEGS-1:0] HS_OL_CLR,
  input wire logic [LEGS-1:0] LS_OL_CLR,
  input wire logic [`HBFM_GS_W-1:0] GLOBAL_CLR,
  output logic [LEGS-1:0] HIGH_SIDE_OVERCURRENT_FLAG,
  output logic [LEGS-1:0] LOW_SIDE_OVERCURRENT_FLAG,
  output logic [LEGS-1:0] HIGH_SIDE_OPEN_LOAD_FLAG,
  output logic [LEGS-1:0] LOW_SIDE_OPEN_LOAD_FLAG,
  output logic [`HBFM_GS_W-1:0] GLOBAL_STATUS_ONE,
  output logic [LEGS-1:0] HS_GATE,
  output logic [LEGS-1:0] LS_GATE,
  output logic FAULT_INDICATOR_N
);
  logic prewarn, tshut, uv, ov, load_err;
  logic [LEGS-1:0] hs_on, ls_on;
  // ************************************
  // global output shutdown
  // ************************************
  wire global_off = tshut | TEMP_SD_DET | SUPPLY_UV_DET | SUPPLY_OV_DET;
  // ************************************
  // legs
  // ************************************
  genvar g;
  generate
    for (g = 0; g < LEGS; g++)
    begin : g_leg
      hbfm_leg #(.FILT_CYC(FILT_CYC), .DEAD_CYC(DEAD_CYC)) u_leg (
        .CLK(CLK),
        .NRST(NRST),
        .en(EN),
        .hs_req(HIGH_SIDE_ENABLE[g]),
        .ls_req(LOW_SIDE_ENABLE[g]),
        .hs_oc_det(HS_OC_DET[g]),
        .ls_oc_det(LS_OC_DET[g]),
        .hs_ol_det(HS_OL_DET[g] & HS_GATE[g]),
        .ls_ol_det(LS_OL_DET[g] & LS_GATE[g]),
        .hs_oc_clr(HS_OC_CLR[g]),
        .ls_oc_clr(LS_OC_CLR[g]),
        .hs_ol_clr(HS_OL_CLR[g]),
        .ls_ol_clr(LS_OL_CLR[g]),
        .global_off(global_off),
        .hs_oc(HIGH_SIDE_OVERCURRENT_FLAG[g]),
        .ls_oc(LOW_SIDE_OVERCURRENT_FLAG[g]),
        .hs_ol(HIGH_SIDE_OPEN_LOAD_FLAG[g]),
        .ls_ol(LOW_SIDE_OPEN_LOAD_FLAG[g]),
        .hs_on(hs_on[g]),
        .ls_on(ls_on[g])
      );
    end
  endgenerate
  // ************************************
  // global flags
  // ************************************
  wire leg_flag_any = |{HIGH_SIDE_OVERCURRENT_FLAG, LOW_SIDE_OVERCURRENT_FLAG,
                        HIGH_SIDE_OPEN_LOAD_FLAG, LOW_SIDE_OPEN_LOAD_FLAG};
  always_ff @(posedge CLK or negedge NRST)
    if (!NRST)
    begin
      prewarn <= 1'b0;
      tshut <= 1'b0;
      uv <= 1'b0;
      ov <= 1'b0;
      load_err <= 1'b0;
    end
    else if (!EN)
    begin
      prewarn <= 1'b0;
      tshut <= 1'b0;
      uv <= 1'b0;
      ov <= 1'b0;
      load_err <= 1'b0;
    end
    else
    begin
      prewarn <= TEMP_WARN_DET | (prewarn & ~GLOBAL_CLR[`HBFM_GS_PREWARN]);
      tshut <= TEMP_SD_DET | (tshut & ~GLOBAL_CLR[`HBFM_GS_TSHUT]);
      uv <= SUPPLY_UV_DET | (uv & ~GLOBAL_CLR[`HBFM_GS_UV]);
      ov <= SUPPLY_OV_DET | (ov & ~GLOBAL_CLR[`HBFM_GS_OV]);
      // summary holds while any per-switch flag remains
      load_err <= leg_flag_any | (load_err & ~GLOBAL_CLR[`HBFM_GS_LOADERR]);
    end
  always_comb
  begin
    GLOBAL_STATUS_ONE = '0;
    GLOBAL_STATUS_ONE[`HBFM_GS_PREWARN] = prewarn;
    GLOBAL_STATUS_ONE[`HBFM_GS_TSHUT] = tshut;
    GLOBAL_STATUS_ONE[`HBFM_GS_OV] = ov;
    GLOBAL_STATUS_ONE[`HBFM_GS_UV] = uv;
    GLOBAL_STATUS_ONE[`HBFM_GS_LOADERR] = load_err;
  end
  // ************************************
  // outputs
  // ************************************
  always_ff @(posedge CLK or negedge NRST)
    if (!NRST)
    begin
      HS_GATE <= '0;
      LS_GATE <= '0;
      FAULT_INDICATOR_N <= 1'b1;
    end
    else
    begin
      HS_GATE <= hs_on & {LEGS{EN & ~global_off}};
      LS_GATE <= ls_on & {LEGS{EN & ~global_off}};
      FAULT_INDICATOR_N <= ~(prewarn | tshut | uv | ov | load_err | leg_flag_any);
    end
endmodule : hbfm_top
`default_nettype wire

/* File: tb/hbfm_top_sva.sv */
// assertions on the ports of the fault manager
`timescale 1ns/100ps
`default_nettype none
module hbfm_top_sva #(parameter int LEGS = 12) (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic EN,
  input wire logic [LEGS-1:0] HS_OL_DET,
  input wire logic [LEGS-1:0] HS_OC_CLR,
  input wire logic [LEGS-1:0] HIGH_SIDE_OVERCURRENT_FLAG,
  input wire logic [LEGS-1:0] LOW_SIDE_OVERCURRENT_FLAG,
  input wire logic [LEGS-1:0] HIGH_SIDE_OPEN_LOAD_FLAG,
  input wire logic [LEGS-1:0] LOW_SIDE_OPEN_LOAD_FLAG,
  input wire logic [7:0] GLOBAL_STATUS_ONE,
  input wire logic [LEGS-1:0] HS_GATE,
  input wire logic [LEGS-1:0] LS_GATE,
  input wire logic FAULT_INDICATOR_N
);
  wire logic leg_flag = |{HIGH_SIDE_OVERCURRENT_FLAG, LOW_SIDE_OVERCURRENT_FLAG, HIGH_SIDE_OPEN_LOAD_FLAG,
    LOW_SIDE_OPEN_LOAD_FLAG};
  wire logic any_flag = leg_flag || (|GLOBAL_STATUS_ONE);
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  a_leg_exclusive: assert property ((HS_GATE & LS_GATE) == '0) else $error("both switches on");
  a_oc_gate_off: assert property (1'b1 |=> (HS_GATE & $past(HIGH_SIDE_OVERCURRENT_FLAG)) == '0)
    else $error("gate on with overcurrent flag");
  a_flag_sticky: assert property (EN |=>
    ($past(HIGH_SIDE_OVERCURRENT_FLAG) & ~HIGH_SIDE_OVERCURRENT_FLAG & ~$past(HS_OC_CLR)) == '0)
    else $error("flag fell without clear");
  a_ol_latch: assert property (EN |=>
    (HIGH_SIDE_OPEN_LOAD_FLAG & $past(HS_OL_DET & HS_GATE)) == $past(HS_OL_DET & HS_GATE))
    else $error("open load not latched");
  a_le_summary: assert property (EN && leg_flag |-> ##[0:1] GLOBAL_STATUS_ONE[6]) else $error("summary missing");
  a_tsd_all_off: assert property (GLOBAL_STATUS_ONE[2] |=> (HS_GATE | LS_GATE) == '0) else $error("gate on in tsd");
  a_pin_low: assert property (EN && any_flag |-> ##[0:1] !FAULT_INDICATOR_N) else $error("pin not low");
  a_pin_release: assert property (!any_flag [*2] |-> FAULT_INDICATOR_N) else $error("pin not released");
  c_oc_seen: cover property (HIGH_SIDE_OVERCURRENT_FLAG != '0);
  c_tsd_seen: cover property (GLOBAL_STATUS_ONE[2]);
  c_pin_release: cover property ($rose(FAULT_INDICATOR_N));
endmodule : hbfm_top_sva
`default_nettype wire

/* File: tb/hbfm_host.sv */
// host model issuing one-cycle flag clears
`timescale 1ns/100ps
`default_nettype none
module hbfm_host (
  input wire logic CLK,
  output logic [11:0] oc_clr,
  output logic [11:0] ol_clr,
  output logic [7:0] g_clr
);
  initial {oc_clr, ol_clr, g_clr} = '0;
  task automatic clear(input logic [11:0] legs, input logic [7:0] glob);
    @(negedge CLK);
    oc_clr = legs;
    ol_clr = legs;
    g_clr = glob;
    @(negedge CLK);
    {oc_clr, ol_clr, g_clr} = '0;
  endtask : clear
endmodule : hbfm_host
`default_nettype wire

/* File: tb/hbfm_top_bench.sv */
// self-checking bench of the fault manager
`timescale 1ns/100ps
`default_nettype none
module hbfm_top_bench;
  logic CLK, NRST, EN, TEMP_WARN_DET, TEMP_SD_DET, SUPPLY_UV_DET, SUPPLY_OV_DET, FAULT_INDICATOR_N;
  logic [11:0] HIGH_SIDE_ENABLE, LOW_SIDE_ENABLE, HS_OC_DET, LS_OC_DET, HS_OL_DET, LS_OL_DET, HS_GATE, LS_GATE;
  logic [11:0] HIGH_SIDE_OVERCURRENT_FLAG, LOW_SIDE_OVERCURRENT_FLAG, HIGH_SIDE_OPEN_LOAD_FLAG;
  logic [11:0] LOW_SIDE_OPEN_LOAD_FLAG, oc_clr, ol_clr;
  logic [7:0] g_clr, GLOBAL_STATUS_ONE;
  int miscompares = 0;
  int checks = 0;
  logic [47:0] rows [5] = '{48'hFFF000FFF000, 48'h000FFF000FFF, 48'h0F000F0F000F, 48'hF0FF0F000000, 48'h0};
  logic [7:0] gbit [4] = '{8'h02, 8'h04, 8'h20, 8'h10};
  hbfm_host host_u (.CLK, .oc_clr, .ol_clr, .g_clr);
  hbfm_top #(.FILT_CYC(4), .DEAD_CYC(3)) dut_u (.CLK, .NRST, .EN, .HIGH_SIDE_ENABLE, .LOW_SIDE_ENABLE,
    .HS_OC_DET, .LS_OC_DET, .HS_OL_DET, .LS_OL_DET, .TEMP_WARN_DET, .TEMP_SD_DET, .SUPPLY_UV_DET,
    .SUPPLY_OV_DET, .HS_OC_CLR(oc_clr), .LS_OC_CLR(oc_clr), .HS_OL_CLR(ol_clr), .LS_OL_CLR(ol_clr),
    .GLOBAL_CLR(g_clr), .HIGH_SIDE_OVERCURRENT_FLAG, .LOW_SIDE_OVERCURRENT_FLAG, .HIGH_SIDE_OPEN_LOAD_FLAG,
    .LOW_SIDE_OPEN_LOAD_FLAG, .GLOBAL_STATUS_ONE, .HS_GATE, .LS_GATE, .FAULT_INDICATOR_N);
  always #2.5 CLK = ~CLK;
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge CLK);
  endtask : cyc
  task automatic complete_run();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : complete_run
  initial
  begin
    {CLK, NRST, EN, TEMP_WARN_DET, TEMP_SD_DET, SUPPLY_UV_DET, SUPPLY_OV_DET} = '0;
    {HIGH_SIDE_ENABLE, LOW_SIDE_ENABLE, HS_OC_DET, LS_OC_DET, HS_OL_DET, LS_OL_DET} = '0;
    cyc(5);
    NRST = 1;
    EN = 1;
    cyc(1);
    chk({GLOBAL_STATUS_ONE, FAULT_INDICATOR_N, HS_GATE}, {8'h00, 1'b1, 12'h000});
    foreach (rows[i])
    begin
      {HIGH_SIDE_ENABLE, LOW_SIDE_ENABLE} = rows[i][47:24];
      cyc(12);
      chk({HS_GATE, LS_GATE}, rows[i][23:0]);
    end
    HIGH_SIDE_ENABLE = 12'hFFF;
    cyc(12);
    HS_OC_DET = 12'h008;
    cyc(8);
    chk({HIGH_SIDE_OVERCURRENT_FLAG, HS_GATE}, {12'h008, 12'hFF7});
    chk({GLOBAL_STATUS_ONE[6], FAULT_INDICATOR_N}, 2'b10);
    host_u.clear(12'h008, 8'h00);
    cyc(12);
    chk({HIGH_SIDE_OVERCURRENT_FLAG, HS_GATE}, {12'h008, 12'hFF7});
    HS_OC_DET = '0;
    host_u.clear(12'h008, 8'h00);
    cyc(12);
    chk({HIGH_SIDE_OVERCURRENT_FLAG, HS_GATE, GLOBAL_STATUS_ONE[6]}, {12'h000, 12'hFFF, 1'b1});
    host_u.clear(12'h000, 8'h40);
    cyc(2);
    chk({GLOBAL_STATUS_ONE, FAULT_INDICATOR_N}, {8'h00, 1'b1});
    {HS_OL_DET, LS_OL_DET} = {12'h020, 12'h020};
    cyc(1);
    {HS_OL_DET, LS_OL_DET} = '0;
    cyc(3);
    chk({HIGH_SIDE_OPEN_LOAD_FLAG, LOW_SIDE_OPEN_LOAD_FLAG, HS_GATE}, {12'h020, 12'h000, 12'hFFF});
    chk({GLOBAL_STATUS_ONE[6], FAULT_INDICATOR_N}, 2'b10);
    host_u.clear(12'h020, 8'h00);
    host_u.clear(12'h000, 8'h40);
    cyc(2);
    chk({HIGH_SIDE_OPEN_LOAD_FLAG, GLOBAL_STATUS_ONE, FAULT_INDICATOR_N}, {12'h000, 8'h00, 1'b1});
    for (int k = 0; k < 4; k++)
    begin
      {TEMP_WARN_DET, TEMP_SD_DET, SUPPLY_UV_DET, SUPPLY_OV_DET} = 4'b1000 >> k;
      cyc(2);
      chk(HS_GATE, (k == 0) ? 12'hFFF : 12'h000);
      {TEMP_WARN_DET, TEMP_SD_DET, SUPPLY_UV_DET, SUPPLY_OV_DET} = '0;
      cyc(12);
      chk({GLOBAL_STATUS_ONE, HS_GATE}, {gbit[k], (k == 1) ? 12'h000 : 12'hFFF});
      host_u.clear(12'h000, gbit[k]);
      cyc(12);
      chk({GLOBAL_STATUS_ONE, HS_GATE}, {8'h00, 12'hFFF});
    end
    HIGH_SIDE_ENABLE = 12'h7FF;
    LOW_SIDE_ENABLE = 12'h800;
    cyc(12);
    {HS_OC_DET, LS_OC_DET} = {12'h001, 12'h800};
    cyc(8);
    chk({LOW_SIDE_OVERCURRENT_FLAG, LS_GATE}, {12'h800, 12'h000});
    chk({HIGH_SIDE_OVERCURRENT_FLAG, HS_GATE}, {12'h001, 12'h7FE});
    {HS_OC_DET, LS_OC_DET} = '0;
    EN = 0;
    cyc(2);
    chk({HIGH_SIDE_OVERCURRENT_FLAG, LOW_SIDE_OVERCURRENT_FLAG, GLOBAL_STATUS_ONE}, 32'h0);
    chk({HS_GATE, LS_GATE, FAULT_INDICATOR_N}, {24'h0, 1'b1});
    complete_run();
  end
  initial
  begin
    #25000;
    miscompares++;
    complete_run();
  end
endmodule : hbfm_top_bench
bind hbfm_top hbfm_top_sva #(.LEGS(LEGS)) chk_u (.CLK, .NRST, .EN, .HS_OL_DET, .HS_OC_CLR,
  .HIGH_SIDE_OVERCURRENT_FLAG, .LOW_SIDE_OVERCURRENT_FLAG, .HIGH_SIDE_OPEN_LOAD_FLAG,
  .LOW_SIDE_OPEN_LOAD_FLAG, .GLOBAL_STATUS_ONE, .HS_GATE, .LS_GATE, .FAULT_INDICATOR_N);
`default_nettype wire
